// file: hdl/hicsp_top.sv
// Top of the hub command and status protocol slave: bit engine over SCL and SDA.
`timescale 1ns/10ps
module hicsp_top
  import hicsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [7:0] cmd_family,
  output logic [7:0] cmd_index,
  output logic [7:0] cmd_data0,
  output logic [4:0] cmd_count,
  output logic cmd_valid,
  input wire logic [3:0] core_verdict,
  input wire logic core_done,
  input wire logic [7:0] core_rd_data,
  output logic [7:0] core_rd_ptr,
  output logic [7:0] status_code
);
  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  // The core clock must run well above SCL; 3400 kbps needs some 29 samples a bit.
  logic [1:0] scl_sync_ff, nxt_scl_sync, sda_sync_ff, nxt_sda_sync;
  logic scl_d_ff, nxt_scl_d, sda_d_ff, nxt_sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_comb begin
    nxt_scl_sync = {scl_sync_ff[0], scl_in};
    nxt_sda_sync = {sda_sync_ff[0], sda_in};
    nxt_scl_d = scl_sync_ff[1];
    nxt_sda_d = sda_sync_ff[1];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync_ff <= 2'b11;
      sda_sync_ff <= 2'b11;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= nxt_scl_sync;
      sda_sync_ff <= nxt_sda_sync;
      scl_d_ff <= nxt_scl_d;
      sda_d_ff <= nxt_sda_d;
    end
  end

  assign scl_rise = scl_sync_ff[1] && !scl_d_ff;
  assign scl_fall = !scl_sync_ff[1] && scl_d_ff;
  assign start_det = scl_sync_ff[1] && scl_d_ff && sda_d_ff && !sda_sync_ff[1];
  assign stop_det = scl_sync_ff[1] && scl_d_ff && !sda_d_ff && sda_sync_ff[1];

  // --------------------------------------------------------------------------
  // Byte engine
  // --------------------------------------------------------------------------
  hicsp_state_t state_ff, nxt_state;
  logic [7:0] shift_ff, nxt_shift;
  logic [3:0] bit_ff, nxt_bit;
  logic drive_low_ff, nxt_drive_low;
  logic nack_ff, nxt_nack;
  logic ev_start, ev_wvalid, ev_stop, ev_rload;
  logic [7:0] ev_wbyte;

  hicsp_link_if link ();

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bit = bit_ff;
    nxt_drive_low = drive_low_ff;
    nxt_nack = nack_ff;
    ev_start = 1'b0;
    ev_wvalid = 1'b0;
    ev_stop = 1'b0;
    ev_rload = 1'b0;
    ev_wbyte = shift_ff;
    if (start_det) begin
      nxt_state = HICSP_ADDR;
      nxt_bit = 4'h0;
      nxt_drive_low = 1'b0;
    end else if (stop_det) begin
      // Every ended frame is reported, so the keeper can rearm the status byte after any read.
      ev_stop = (state_ff != HICSP_IDLE);
      nxt_state = HICSP_IDLE;
      nxt_drive_low = 1'b0;
    end else begin
      case (state_ff)
        HICSP_IDLE, HICSP_IGNORE: begin
          nxt_drive_low = 1'b0;
        end
        HICSP_ADDR, HICSP_WBYTE: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_sync_ff[1]};
            nxt_bit = bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            nxt_bit = 4'h0;
            if (state_ff == HICSP_WBYTE) begin
              ev_wvalid = 1'b1;
              nxt_drive_low = 1'b0;
              nxt_state = HICSP_WACK;
            end else if (shift_ff[7:1] == HICSP_SLAVE_ADDR) begin
              ev_start = !shift_ff[0];
              nxt_drive_low = 1'b0;
              nxt_state = HICSP_AACK;
            end else begin
              nxt_state = HICSP_IGNORE;
            end
          end
        end
        HICSP_AACK, HICSP_WACK: begin
          // The ack low is applied here, after SCL fell, so SDA never moves while SCL is high.
          if (bit_ff == 4'h0) begin
            nxt_drive_low = 1'b1;
            nxt_bit = 4'h1;
          end else if (scl_fall) begin
            nxt_bit = 4'h0;
            if (state_ff == HICSP_AACK && shift_ff[0]) begin
              ev_rload = 1'b1;
              nxt_shift = link.rd_byte;
              nxt_drive_low = !link.rd_byte[7];
              nxt_state = HICSP_RBYTE;
            end else begin
              nxt_drive_low = 1'b0;
              nxt_state = HICSP_WBYTE;
            end
          end
        end
        HICSP_RBYTE: begin
          if (scl_fall) begin
            if (bit_ff == 4'h7) begin
              nxt_drive_low = 1'b0;
              nxt_bit = 4'h0;
              nxt_state = HICSP_RACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_drive_low = !shift_ff[6];
              nxt_bit = bit_ff + 4'h1;
            end
          end
        end
        HICSP_RACK: begin
          if (scl_rise) begin
            nxt_nack = sda_sync_ff[1];
          end else if (scl_fall) begin
            if (nack_ff) begin
              nxt_state = HICSP_IGNORE;
            end else begin
              ev_rload = 1'b1;
              nxt_shift = link.rd_byte;
              nxt_drive_low = !link.rd_byte[7];
              nxt_state = HICSP_RBYTE;
            end
          end
        end
        default: begin
          nxt_state = HICSP_IDLE;
          nxt_drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= HICSP_IDLE;
      shift_ff <= 8'h00;
      bit_ff <= 4'h0;
      drive_low_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bit_ff <= nxt_bit;
      drive_low_ff <= nxt_drive_low;
      nack_ff <= nxt_nack;
    end
  end

  assign link.frame_start = ev_start;
  assign link.wr_byte_valid = ev_wvalid;
  assign link.wr_byte = ev_wbyte;
  assign link.frame_stop = ev_stop;
  assign link.rd_load = ev_rload;
  assign sda_out = 1'b0;
  assign sda_oe_n = !drive_low_ff;

  hicsp_status_keeper u_keeper (
    .clk(clk),
    .reset(reset),
    .link(link),
    .cmd_family(cmd_family),
    .cmd_index(cmd_index),
    .cmd_data0(cmd_data0),
    .cmd_count(cmd_count),
    .cmd_valid(cmd_valid),
    .core_verdict(core_verdict),
    .core_done(core_done),
    .core_rd_data(core_rd_data),
    .core_rd_ptr(core_rd_ptr),
    .status_code(status_code)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence addr_match_s;
    state_ff == HICSP_ADDR && scl_fall && bit_ff == 4'h8 && shift_ff[7:1] == HICSP_SLAVE_ADDR;
  endsequence
  sequence quiet_s;
    !start_det && !stop_det;
  endsequence
  addr_ack_a: assert property (@(posedge clk) disable iff (reset)
    (addr_match_s and quiet_s) ##1 quiet_s |=> !sda_oe_n)
    else $error("own address not acknowledged");
  foreign_addr_a: assert property (@(posedge clk) disable iff (reset)
    ((state_ff == HICSP_ADDR && scl_fall && bit_ff == 4'h8
    && shift_ff[7:1] != HICSP_SLAVE_ADDR) and quiet_s) |=> state_ff == HICSP_IGNORE)
    else $error("foreign address not ignored");
  ack_hold_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == HICSP_WACK && bit_ff == 4'h1 && !scl_fall && quiet_s) |=> !sda_oe_n)
    else $error("write byte ack released early");
  status_first_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == HICSP_AACK && bit_ff == 4'h1 && scl_fall && shift_ff[0] && quiet_s)
    |=> shift_ff == $past(link.rd_byte) && state_ff == HICSP_RBYTE)
    else $error("read phase did not load status byte");
  no_drive_idle_a: assert property (@(posedge clk) disable iff (reset)
    state_ff == HICSP_IDLE |=> ##1 (state_ff != HICSP_IDLE || sda_oe_n))
    else $error("sda driven while idle");
endmodule

// file: hdl/hicsp_pkg.sv
// Package with constants and types for the hub command and status protocol block.
package hicsp_pkg;
  // --------------------------------------------------------------------------
  // Bus addressing and rate limit
  // --------------------------------------------------------------------------
  localparam logic [6:0] HICSP_SLAVE_ADDR = 7'h55;
  localparam logic [7:0] HICSP_WRITE_ADDR_BYTE = 8'hAA;
  localparam logic [7:0] HICSP_READ_ADDR_BYTE = 8'hAB;
  localparam int HICSP_MAX_RATE_KBPS = 3400;
  // --------------------------------------------------------------------------
  // Status codes
  // --------------------------------------------------------------------------
  localparam logic [7:0] HICSP_STATUS_SUCCESS = 8'h00;
  localparam logic [7:0] HICSP_STATUS_BAD_COMMAND = 8'h01;
  localparam logic [7:0] HICSP_STATUS_NOT_IMPLEMENTED = 8'h02;
  localparam logic [7:0] HICSP_STATUS_BAD_LENGTH = 8'h03;
  localparam logic [7:0] HICSP_STATUS_BAD_VALUE = 8'h04;
  localparam logic [7:0] HICSP_STATUS_BUSY = 8'h05;
  localparam logic [7:0] HICSP_STATUS_LOADER_PAGE_FAULT = 8'h80;
  localparam logic [7:0] HICSP_STATUS_LOADER_CHECK_FAULT = 8'h81;
  localparam logic [7:0] HICSP_STATUS_LOADER_AUTH_FAULT = 8'h82;
  localparam logic [7:0] HICSP_STATUS_LOADER_IMAGE_INVALID = 8'h83;
  localparam logic [7:0] HICSP_STATUS_UNKNOWN = 8'hFF;
  localparam logic [7:0] HICSP_STATUS_RESET = 8'h00;
  // --------------------------------------------------------------------------
  // Core verdict encoding
  // --------------------------------------------------------------------------
  localparam logic [3:0] HICSP_V_OK = 4'h0;
  localparam logic [3:0] HICSP_V_BAD_CMD = 4'h1;
  localparam logic [3:0] HICSP_V_NO_FUNC = 4'h2;
  localparam logic [3:0] HICSP_V_BAD_LEN = 4'h3;
  localparam logic [3:0] HICSP_V_BAD_VAL = 4'h4;
  localparam logic [3:0] HICSP_V_BUSY = 4'h5;
  localparam logic [3:0] HICSP_V_PAGE = 4'h6;
  localparam logic [3:0] HICSP_V_CHECK = 4'h7;
  localparam logic [3:0] HICSP_V_AUTH = 4'h8;
  localparam logic [3:0] HICSP_V_IMAGE = 4'h9;
  // --------------------------------------------------------------------------
  // Timing and write length limit
  // --------------------------------------------------------------------------
  localparam int HICSP_CMD_DELAY_US = 2000;
  localparam int HICSP_CLK_MHZ = 100;
  localparam int HICSP_CMD_DELAY_CYC = HICSP_CMD_DELAY_US * HICSP_CLK_MHZ;
  localparam int HICSP_MAX_WR_BYTES = 16;
  // --------------------------------------------------------------------------
  // Bit engine states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    HICSP_IDLE = 3'b000,
    HICSP_ADDR = 3'b001,
    HICSP_AACK = 3'b011,
    HICSP_WBYTE = 3'b010,
    HICSP_WACK = 3'b110,
    HICSP_RBYTE = 3'b111,
    HICSP_RACK = 3'b101,
    HICSP_IGNORE = 3'b100
  } hicsp_state_t;
endpackage

// file: hdl/hicsp_link_if.sv
// Interface carrying decoded frame events between the protocol engine and the status keeper.
`timescale 1ns/10ps
interface hicsp_link_if;
  logic frame_start;
  logic wr_byte_valid;
  logic [7:0] wr_byte;
  logic frame_stop;
  logic rd_load;
  logic [7:0] rd_byte;
  modport engine (output frame_start, output wr_byte_valid, output wr_byte, output frame_stop,
    output rd_load, input rd_byte);
  modport keeper (input frame_start, input wr_byte_valid, input wr_byte, input frame_stop,
    input rd_load, output rd_byte);
endinterface

// file: hdl/hicsp_status_keeper.sv
// Status keeper: holds the first three bytes and the byte count of the written frame, the status code and the read-back pointer.
`timescale 1ns/10ps
module hicsp_status_keeper
  import hicsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  hicsp_link_if.keeper link,
  output logic [7:0] cmd_family,
  output logic [7:0] cmd_index,
  output logic [7:0] cmd_data0,
  output logic [4:0] cmd_count,
  output logic cmd_valid,
  input wire logic [3:0] core_verdict,
  input wire logic core_done,
  input wire logic [7:0] core_rd_data,
  output logic [7:0] core_rd_ptr,
  output logic [7:0] status_code
);
  logic [7:0] fam_ff, nxt_fam, idx_ff, nxt_idx, dat_ff, nxt_dat, stat_ff, nxt_stat;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [7:0] ptr_ff, nxt_ptr;
  logic first_ff, nxt_first, valid_ff, nxt_valid, pend_ff, nxt_pend;
  logic open_ff, nxt_open, cmd_end;

  // Only a write frame that carried bytes is a command; a read frame's STOP must not restart it.
  assign cmd_end = link.frame_stop && open_ff && cnt_ff != 5'h00;

  function automatic logic [7:0] code_of(input logic [3:0] v);
    case (v)
      HICSP_V_OK: code_of = HICSP_STATUS_SUCCESS;
      HICSP_V_BAD_CMD: code_of = HICSP_STATUS_BAD_COMMAND;
      HICSP_V_NO_FUNC: code_of = HICSP_STATUS_NOT_IMPLEMENTED;
      HICSP_V_BAD_LEN: code_of = HICSP_STATUS_BAD_LENGTH;
      HICSP_V_BAD_VAL: code_of = HICSP_STATUS_BAD_VALUE;
      HICSP_V_BUSY: code_of = HICSP_STATUS_BUSY;
      HICSP_V_PAGE: code_of = HICSP_STATUS_LOADER_PAGE_FAULT;
      HICSP_V_CHECK: code_of = HICSP_STATUS_LOADER_CHECK_FAULT;
      HICSP_V_AUTH: code_of = HICSP_STATUS_LOADER_AUTH_FAULT;
      HICSP_V_IMAGE: code_of = HICSP_STATUS_LOADER_IMAGE_INVALID;
      default: code_of = HICSP_STATUS_UNKNOWN;
    endcase
  endfunction

  always_comb begin
    nxt_fam = fam_ff;
    nxt_idx = idx_ff;
    nxt_dat = dat_ff;
    nxt_cnt = cnt_ff;
    nxt_stat = stat_ff;
    nxt_ptr = ptr_ff;
    nxt_first = first_ff;
    nxt_valid = 1'b0;
    nxt_pend = pend_ff;
    nxt_open = open_ff;
    if (link.frame_start) begin
      nxt_cnt = 5'h00;
      nxt_first = 1'b1;
      nxt_open = 1'b1;
    end
    if (link.frame_stop) begin
      nxt_open = 1'b0;
      nxt_first = 1'b1;
    end
    if (link.wr_byte_valid) begin
      if (cnt_ff == 5'h00) begin
        nxt_fam = link.wr_byte;
      end else if (cnt_ff == 5'h01) begin
        nxt_idx = link.wr_byte;
      end else if (cnt_ff == 5'h02) begin
        nxt_dat = link.wr_byte;
      end
      if (cnt_ff != 5'h1F) begin
        nxt_cnt = cnt_ff + 5'h01;
      end
    end
    // Status stays busy until the core answers; a repeated read returns it unchanged.
    if (cmd_end) begin
      nxt_valid = 1'b1;
      nxt_pend = 1'b1;
      nxt_stat = HICSP_STATUS_BUSY;
      nxt_ptr = 8'h00;
    end else if (pend_ff && core_done) begin
      nxt_pend = 1'b0;
      nxt_stat = code_of(core_verdict);
    end
    if (link.rd_load) begin
      if (first_ff) begin
        nxt_first = 1'b0;
      end else begin
        nxt_ptr = ptr_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fam_ff <= 8'h00;
      idx_ff <= 8'h00;
      dat_ff <= 8'h00;
      cnt_ff <= 5'h00;
      stat_ff <= HICSP_STATUS_RESET;
      ptr_ff <= 8'h00;
      first_ff <= 1'b1;
      valid_ff <= 1'b0;
      pend_ff <= 1'b0;
      open_ff <= 1'b0;
    end else begin
      fam_ff <= nxt_fam;
      idx_ff <= nxt_idx;
      dat_ff <= nxt_dat;
      cnt_ff <= nxt_cnt;
      stat_ff <= nxt_stat;
      ptr_ff <= nxt_ptr;
      first_ff <= nxt_first;
      valid_ff <= nxt_valid;
      pend_ff <= nxt_pend;
      open_ff <= nxt_open;
    end
  end

  // The status byte leads the first read phase after reset, a STOP or a write address; data follows from the selected location.
  assign link.rd_byte = first_ff ? stat_ff : core_rd_data;
  assign cmd_family = fam_ff;
  assign cmd_index = idx_ff;
  assign cmd_data0 = dat_ff;
  assign cmd_count = cnt_ff;
  assign cmd_valid = valid_ff;
  assign core_rd_ptr = ptr_ff;
  assign status_code = stat_ff;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  busy_after_frame_a: assert property (@(posedge clk) disable iff (reset)
    cmd_end |=> (stat_ff == HICSP_STATUS_BUSY) && cmd_valid)
    else $error("status not busy after frame");
  ok_verdict_a: assert property (@(posedge clk) disable iff (reset)
    (pend_ff && core_done && core_verdict == HICSP_V_OK && !link.frame_stop)
    |=> stat_ff == HICSP_STATUS_SUCCESS)
    else $error("success code not reported");
  badcmd_verdict_a: assert property (@(posedge clk) disable iff (reset)
    (pend_ff && core_done && core_verdict == HICSP_V_BAD_CMD && !link.frame_stop)
    |=> stat_ff == HICSP_STATUS_BAD_COMMAND)
    else $error("bad command code not reported");
  status_hold_a: assert property (@(posedge clk) disable iff (reset)
    (!pend_ff && !link.frame_stop) |=> $stable(stat_ff))
    else $error("status changed without a frame");
  ptr_reset_a: assert property (@(posedge clk) disable iff (reset)
    cmd_end |=> ptr_ff == 8'h00)
    else $error("read pointer not rewound");
  read_stop_hold_a: assert property (@(posedge clk) disable iff (reset)
    (link.frame_stop && !open_ff && !pend_ff) |=> $stable(stat_ff) && !cmd_valid)
    else $error("read frame changed the status");
endmodule

// file: testbench/hicsp_host_model.sv
// Host model: an I2C bus master that frames commands and reads back status.
`timescale 1ns/10ps
module hicsp_host_model (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  // Quarter bit time in core clocks; the bench raises it to act as a slow host.
  int q = 8;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Bus conditions and bit slots
  // --------------------------------------------------------------------------
  task automatic wq();
    repeat (q) @(posedge clk);
  endtask

  // SDA only moves a full quarter after SCL falls, so the slave never sees a false START.
  task automatic bit_slot(input logic b, output logic s);
    sda_low <= ~b;
    wq();
    scl <= 1'b1;
    wq();
    s = sda_wire;
    wq();
    scl <= 1'b0;
    wq();
  endtask

  task automatic start_cond();
    sda_low <= 1'b0;
    wq();
    scl <= 1'b1;
    wq();
    sda_low <= 1'b1;
    wq();
    scl <= 1'b0;
    wq();
  endtask

  task automatic stop_cond();
    sda_low <= 1'b1;
    wq();
    scl <= 1'b1;
    wq();
    sda_low <= 1'b0;
    wq();
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], s);
    end
    bit_slot(1'b1, s);
    ack = ~s;
  endtask

  // A low ninth bit acknowledges; a byte fetched with last high is left unacknowledged.
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      d[i] = s;
    end
    bit_slot(last, s);
  endtask
endmodule

// file: testbench/tb_hicsp_top.sv
// Self-checking testbench for the hub command and status protocol slave.
`timescale 1ns/10ps
module tb_hicsp_top
  import hicsp_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sda_wire;
  logic scl_in;
  logic sda_out;
  logic sda_oe_n;
  logic host_sda_low;
  logic [7:0] cmd_family;
  logic [7:0] cmd_index;
  logic [7:0] cmd_data0;
  logic [4:0] cmd_count;
  logic cmd_valid;
  logic [3:0] core_verdict = 4'h0;
  logic core_done = 1'b0;
  logic [7:0] core_rd_data;
  logic [7:0] core_rd_ptr;
  logic [7:0] status_code;
  int fails = 0;
  int n_compared = 0;
  int n_valid = 0;

  always #5 clk = ~clk;

  // Open-drain SDA with a pull-up: low when either party pulls it.
  assign sda_wire = ~(host_sda_low | (~sda_oe_n & ~sda_out));
  // Core model; bit 7 is kept high so a STOP after an acknowledged status byte is never blocked.
  assign core_rd_data = {1'b1, cmd_family[2:0] ^ cmd_index[2:0], core_rd_ptr[3:0]};

  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_valid++;
  end

  hicsp_top hicsp_top_i (.clk, .reset, .scl_in, .sda_in(sda_wire), .sda_out, .sda_oe_n,
    .cmd_family, .cmd_index, .cmd_data0, .cmd_count, .cmd_valid, .core_verdict, .core_done,
    .core_rd_data, .core_rd_ptr, .status_code);

  hicsp_host_model host_i (.clk, .sda_wire, .scl(scl_in), .sda_low(host_sda_low));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic write_frame(input logic [7:0] b[$]);
    logic ack;
    int v0;
    v0 = n_valid;
    host_i.start_cond();
    host_i.send_byte(HICSP_WRITE_ADDR_BYTE, ack);
    check({7'h00, ack}, 8'h01);
    foreach (b[i]) begin
      host_i.send_byte(b[i], ack);
      check({7'h00, ack}, 8'h01);
    end
    host_i.stop_cond();
    repeat (4) @(posedge clk);
    check(8'(n_valid - v0), 8'h01);
    check(status_code, 8'h05);
    check({3'h0, cmd_count}, 8'(b.size()));
    check(cmd_family, b[0]);
    check(cmd_index, b[1]);
    if (b.size() > 2) check(cmd_data0, b[2]);
  endtask

  task automatic core_answer(input logic [3:0] v, input logic [7:0] exp);
    core_verdict <= v;
    core_done <= 1'b1;
    @(posedge clk);
    core_done <= 1'b0;
    repeat (3) @(posedge clk);
    check(status_code, exp);
  endtask

  task automatic read_phase(input logic [7:0] exp, input int n, input logic [7:0] f,
    input logic [7:0] x);
    logic ack;
    logic [7:0] d;
    // The command delay is scaled down a thousandfold to keep the run short; the slave never times it.
    repeat (HICSP_CMD_DELAY_CYC / 1000) @(posedge clk);
    host_i.start_cond();
    host_i.send_byte(HICSP_READ_ADDR_BYTE, ack);
    check({7'h00, ack}, 8'h01);
    host_i.get_byte(1'b0, d);
    check(d, exp);
    for (int i = 0; i < n; i++) begin
      host_i.get_byte(i == n - 1, d);
      check(d, {1'b1, f[2:0] ^ x[2:0], 4'(i)});
    end
    host_i.stop_cond();
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_verdicts();
    logic [7:0] codes [0:10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h80, 8'h81,
      8'h82, 8'h83, 8'hFF};
    logic [7:0] b[$];
    for (int i = 0; i < 11; i++) begin
      b = '{8'(i + 1), 8'(i * 3)};
      repeat (i % 3) b.push_back(8'(8'h40 + i));
      write_frame(b);
      core_answer(4'(i), codes[i]);
      read_phase(codes[i], 0, b[0], b[1]);
    end
    $display("test verdicts done");
  endtask

  task automatic t_read_data();
    logic ack;
    int v0;
    write_frame('{8'h02, 8'h00});
    core_answer(4'h0, 8'h00);
    read_phase(8'h00, 3, 8'h02, 8'h00);
    read_phase(8'h00, 0, 8'h02, 8'h00);
    core_answer(4'h1, 8'h00);
    v0 = n_valid;
    host_i.start_cond();
    host_i.send_byte(8'hA0, ack);
    check({7'h00, ack}, 8'h00);
    host_i.send_byte(8'h07, ack);
    host_i.stop_cond();
    repeat (4) @(posedge clk);
    check(8'(n_valid - v0), 8'h00);
    check(status_code, 8'h00);
    $display("test read data done");
  endtask

  task automatic t_busy();
    host_i.q = 20;
    write_frame('{8'h01, 8'h00, 8'h08});
    read_phase(8'h05, 0, 8'h01, 8'h00);
    core_answer(4'h0, 8'h00);
    read_phase(8'h00, 0, 8'h01, 8'h00);
    host_i.q = 8;
    $display("test busy done");
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The full run takes roughly 33000 cycles; the watchdog allows close to twice that.
  initial begin
    repeat (70000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    check(status_code, 8'h00);
    t_verdicts();
    t_read_data();
    t_busy();
    report_and_stop();
  end
endmodule
